// *** rtl/stm_consts.vh ***
// Purpose: shared constants of the standard timer core
// Assumes: APB word map, 8-bit registers in the low byte lane
// Notes: offsets are byte addresses
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
// =====================================================================
// register map
`define STM_OFS_CTRL0 8'h00
`define STM_OFS_CTRL1 8'h04
`define STM_OFS_CNT_LO 8'h08
`define STM_OFS_CNT_HI 8'h0C
`define STM_OFS_CMPA_LO 8'h10
`define STM_OFS_CMPA_HI 8'h14
`define STM_OFS_PERIOD 8'h18
`define STM_ADDR_W 8
// =====================================================================
// reset values
`define STM_RST_CTRL0 8'h00
`define STM_RST_CTRL1 8'h00
`define STM_RST_CMPA 16'h0000
`define STM_RST_PERIOD 8'h00
// =====================================================================
// timer_control_0 fields
`define STM_C0_PAUSE 7
`define STM_C0_CKS_HI 6
`define STM_C0_CKS_LO 4
`define STM_C0_ENABLE 3
`define STM_C0_WMASK 8'hF8
// timer_control_1 fields
`define STM_C1_MODE_HI 7
`define STM_C1_MODE_LO 6
`define STM_C1_FUNC_HI 5
`define STM_C1_FUNC_LO 4
`define STM_C1_OCTL 3
`define STM_C1_POL 2
`define STM_C1_SWAP 1
`define STM_C1_CLRSEL 0
// =====================================================================
// modes and clock selects
`define STM_MODE_CMP 2'b00
`define STM_MODE_CAP 2'b01
`define STM_MODE_PWM 2'b10
`define STM_MODE_TMR 2'b11
`define STM_CKS_SYS4 3'b000
`define STM_CKS_SYS 3'b001
`define STM_CKS_IH16 3'b010
`define STM_CKS_IH64 3'b011
`define STM_CKS_SUB0 3'b100
`define STM_CKS_SUB1 3'b101
`define STM_CKS_EXTR 3'b110
`define STM_CKS_EXTF 3'b111
// =====================================================================
// prescaler terminal counts
`define STM_DIV_SYS4 6'h03
`define STM_DIV_IH16 6'h0F
`define STM_DIV_IH64 6'h3F
`endif

// *** rtl/stm_timer_core.v ***
// Purpose: 16-bit standard timer core with APB register access
// Assumes: pclk is the system clock; other clocks arrive as pins
// Notes: pready is low in reset and high from the first clock after it, so every transfer has no wait state
`timescale 1ns/100ps
`default_nettype none
`include "stm_consts.vh"

// Notes on behaviour
// - 16-bit up-counter, software-chosen clock source
// - period vs high byte, compare-A vs all
// - clear only by enable rise, overflow, match
// - request pulse on overflow or match clear
// - pause bit holds counter, resumes later
// - three-bit clock select decoding
// - enable bit runs counter, clear stops it
// - enable rise zeroes counter, fall keeps it
// - enable rise restores initial output level
// - control 0 bits 2..0 read zero
// - two-bit mode field selects operation
// - timer mode output shows held level
// - compare mode: keep, low, high, toggle
// - pwm mode: inactive, active, pwm, pulse
// - capture edge select or capture off
// - counter, compare-A, period, two control registers
// - clock and capture inputs, two outputs
// - output control: initial level or active level
// - clear select: compare-A or period/overflow
// - period zero means 65536, else times 256
// - swap bit exchanges duty and period roles
module stm_timer_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`STM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_clock_pin,
  input wire capture_input_pin,
  input wire internal_high_clock,
  input wire sub_clock,
  output reg timer_output,
  output reg timer_output_b,
  output reg compare_a_event,
  output reg period_event
);

  // ===================================================================
  // registers
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [15:0] cmpa_q;
  reg [7:0] period_q;
  reg [15:0] cnt_q;
  reg en_prev_q;
  reg level_q;
  reg [5:0] pre_q;
  reg [2:0] ext_s_q;
  reg [2:0] cap_s_q;
  reg [2:0] ih_s_q;
  reg [2:0] sub_s_q;

  wire [2:0] clk_sel = ctrl0_q[`STM_C0_CKS_HI:`STM_C0_CKS_LO];
  wire timer_enable = ctrl0_q[`STM_C0_ENABLE];
  wire counter_pause = ctrl0_q[`STM_C0_PAUSE];
  wire [1:0] mode_select = ctrl1_q[`STM_C1_MODE_HI:`STM_C1_MODE_LO];
  wire [1:0] output_function = ctrl1_q[`STM_C1_FUNC_HI:`STM_C1_FUNC_LO];
  wire output_control = ctrl1_q[`STM_C1_OCTL];
  wire output_polarity = ctrl1_q[`STM_C1_POL];
  wire duty_period_swap = ctrl1_q[`STM_C1_SWAP];
  wire clear_select = ctrl1_q[`STM_C1_CLRSEL];

  // address decode used for both read and write paths
  function is_addr;
    input [`STM_ADDR_W-1:0] a;
    input [`STM_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  wire setup_ph = psel & ~penable;
  wire wr_stb = psel & penable & pwrite;
  wire mapped = is_addr(paddr, `STM_OFS_CTRL0) |
    is_addr(paddr, `STM_OFS_CTRL1) | is_addr(paddr, `STM_OFS_CNT_LO) |
    is_addr(paddr, `STM_OFS_CNT_HI) | is_addr(paddr, `STM_OFS_CMPA_LO) |
    is_addr(paddr, `STM_OFS_CMPA_HI) | is_addr(paddr, `STM_OFS_PERIOD);

  // ===================================================================
  // pin synchronisers
  // three flops per pin
  // stage 0 is read only by stage 1; edges use stages 1 and 2
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s_q <= 3'b000;
      cap_s_q <= 3'b000;
      ih_s_q <= 3'b000;
      sub_s_q <= 3'b000;
    end else begin
      ext_s_q <= {ext_s_q[1:0], ext_clock_pin};
      cap_s_q <= {cap_s_q[1:0], capture_input_pin};
      ih_s_q <= {ih_s_q[1:0], internal_high_clock};
      sub_s_q <= {sub_s_q[1:0], sub_clock};
    end
  end

  wire ext_rise = ext_s_q[1] & ~ext_s_q[2];
  wire ext_fall = ~ext_s_q[1] & ext_s_q[2];
  wire cap_rise = cap_s_q[1] & ~cap_s_q[2];
  wire cap_fall = ~cap_s_q[1] & cap_s_q[2];
  wire ih_rise = ih_s_q[1] & ~ih_s_q[2];
  wire sub_rise = sub_s_q[1] & ~sub_s_q[2];

  // ===================================================================
  // clock source selection
  // prescaler counts pclk or high-clock edges, per select
  wire pre_src = (clk_sel == `STM_CKS_SYS4) ? 1'b1 : ih_rise;
  reg [5:0] pre_top;
  reg src_tick;
  always @* begin
    pre_top = `STM_DIV_SYS4;
    src_tick = 1'b0;
    case (clk_sel)
      `STM_CKS_SYS4: begin
        pre_top = `STM_DIV_SYS4;
        src_tick = (pre_q == `STM_DIV_SYS4);
      end
      `STM_CKS_SYS: src_tick = 1'b1;
      `STM_CKS_IH16: begin
        pre_top = `STM_DIV_IH16;
        src_tick = ih_rise & (pre_q == `STM_DIV_IH16);
      end
      `STM_CKS_IH64: begin
        pre_top = `STM_DIV_IH64;
        src_tick = ih_rise & (pre_q == `STM_DIV_IH64);
      end
      `STM_CKS_SUB0: src_tick = sub_rise;
      `STM_CKS_SUB1: src_tick = sub_rise;
      `STM_CKS_EXTR: src_tick = ext_rise;
      `STM_CKS_EXTF: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  // prescaler stays at zero while off, so a restart is phase-aligned
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
    end else if (!timer_enable) begin
      pre_q <= 6'h00;
    end else if (pre_src) begin
      if (pre_q >= pre_top) begin
        pre_q <= 6'h00;
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  // ===================================================================
  // comparators and clear conditions
  wire en_rise = timer_enable & ~en_prev_q;
  wire tick = timer_enable & ~counter_pause & ~en_rise & src_tick;
  wire [15:0] cnt_nx = cnt_q + 16'h0001;
  // period sees the high byte only
  // period n spans n times 256 clocks
  wire match_p = (period_q != 8'h00) && (cnt_nx[15:8] == period_q) &&
    (cnt_nx[7:0] == 8'h00);
  wire match_a = (cnt_nx == cmpa_q);
  wire ovf = (cnt_q == 16'hFFFF);
  wire pwm_mode = (mode_select == `STM_MODE_PWM);
  wire cap_mode = (mode_select == `STM_MODE_CAP);
  // period zero lets the count wrap at 65536
  wire p_end = match_p | (ovf & (period_q == 8'h00));
  reg clr_cnt;
  // clear select picks the clearing comparator
  // in pwm the swap bit picks the period source
  always @* begin
    clr_cnt = 1'b0;
    if (pwm_mode) begin
      clr_cnt = duty_period_swap ? (match_a | ovf) : p_end;
    end else if (cap_mode) begin
      clr_cnt = ovf;
    end else begin
      clr_cnt = clear_select ? (match_a | ovf) : p_end;
    end
  end

  // ===================================================================
  // capture edge selection
  reg cap_evt;
  always @* begin
    case (output_function)
      2'b00: cap_evt = cap_rise;
      2'b01: cap_evt = cap_fall;
      2'b10: cap_evt = cap_rise | cap_fall;
      default: cap_evt = 1'b0;
    endcase
  end
  wire do_capture = cap_mode & timer_enable & cap_evt;

  // ===================================================================
  // pwm duty window
  // duty at or above period gives full duty
  wire [16:0] duty_end = duty_period_swap ?
    ((period_q == 8'h00) ? 17'h1_0000 : {1'b0, period_q, 8'h00}) :
    {1'b0, cmpa_q};
  wire duty_on = ({1'b0, cnt_q} < duty_end);
  // single pulse ends on its duty compare
  wire sp_mode = pwm_mode & (output_function == 2'b11);
  wire duty_hit = duty_period_swap ? match_p : match_a;
  wire sp_end = sp_mode & tick & duty_hit;

  // ===================================================================
  // apb write path and control registers
  // register set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= `STM_RST_CTRL0;
      ctrl1_q <= `STM_RST_CTRL1;
      period_q <= `STM_RST_PERIOD;
    end else begin
      if (wr_stb && is_addr(paddr, `STM_OFS_CTRL0)) begin
        ctrl0_q <= pwdata[7:0] & `STM_C0_WMASK;
      end else if (sp_end) begin
        ctrl0_q[`STM_C0_ENABLE] <= 1'b0;
      end
      if (wr_stb && is_addr(paddr, `STM_OFS_CTRL1)) begin
        ctrl1_q <= pwdata[7:0];
      end
      if (wr_stb && is_addr(paddr, `STM_OFS_PERIOD)) begin
        period_q <= pwdata[7:0];
      end
    end
  end

  // compare-A halves; a capture overrides a software write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_q <= `STM_RST_CMPA;
    end else if (do_capture) begin
      cmpa_q <= cnt_q;
    end else if (wr_stb && is_addr(paddr, `STM_OFS_CMPA_LO)) begin
      cmpa_q[7:0] <= pwdata[7:0];
    end else if (wr_stb && is_addr(paddr, `STM_OFS_CMPA_HI)) begin
      cmpa_q[15:8] <= pwdata[7:0];
    end
  end

  // ===================================================================
  // counter
  // no software load path exists
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= timer_enable;
      if (en_rise) begin
        cnt_q <= 16'h0000;
      end else if (tick) begin
        cnt_q <= clr_cnt ? 16'h0000 : cnt_nx;
      end
    end
  end

  // ===================================================================
  // request pulses
  // pulse on match or overflow clear
  // no period request when clear select gives compare-A the clear outside pwm
  wire a_evt = tick & ((match_a & ~cap_mode) | do_capture);
  wire p_evt = tick & p_end & ~cap_mode &
    ~(~pwm_mode & clear_select);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_event <= 1'b0;
      period_event <= 1'b0;
    end else begin
      compare_a_event <= a_evt | (do_capture & ~tick);
      period_event <= p_evt;
    end
  end

  // ===================================================================
  // output level
  // output control sets initial or active level
  // compare-mode level, toggled by compare-A only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (en_rise) begin
      level_q <= output_control;
    end else if (mode_select == `STM_MODE_CMP && tick && match_a) begin
      case (output_function)
        2'b00: level_q <= level_q;
        2'b01: level_q <= 1'b0;
        2'b10: level_q <= 1'b1;
        default: level_q <= ~level_q;
      endcase
    end
  end

  reg pin_d;
  // timer mode just shows the held level
  always @* begin
    pin_d = level_q;
    if (pwm_mode) begin
      case (output_function)
        2'b00: pin_d = ~output_control;
        2'b01: pin_d = output_control;
        2'b10: pin_d = duty_on ? output_control : ~output_control;
        default: pin_d = (timer_enable & duty_on) ?
          output_control : ~output_control;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output <= 1'b0;
      timer_output_b <= 1'b1;
    end else begin
      timer_output <= pin_d ^ output_polarity;
      timer_output_b <= ~(pin_d ^ output_polarity);
    end
  end

  // ===================================================================
  // apb read path, captured in the setup cycle
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (is_addr(paddr, `STM_OFS_CTRL0)) begin
      rd_byte = ctrl0_q & `STM_C0_WMASK;
    end else if (is_addr(paddr, `STM_OFS_CTRL1)) begin
      rd_byte = ctrl1_q;
    end else if (is_addr(paddr, `STM_OFS_CNT_LO)) begin
      rd_byte = cnt_q[7:0];
    end else if (is_addr(paddr, `STM_OFS_CNT_HI)) begin
      rd_byte = cnt_q[15:8];
    end else if (is_addr(paddr, `STM_OFS_CMPA_LO)) begin
      rd_byte = cmpa_q[7:0];
    end else if (is_addr(paddr, `STM_OFS_CMPA_HI)) begin
      rd_byte = cmpa_q[15:8];
    end else if (is_addr(paddr, `STM_OFS_PERIOD)) begin
      rd_byte = period_q;
    end
  end

  // read data sampled one cycle early, so counter reads lag by one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        prdata <= {24'h00_0000, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/stm_pin_model.sv ***
// Purpose: pin-side partner of the timer core
// Assumes: all pins are asynchronous to pclk
// Notes: clocks stay slower than half of pclk
`timescale 1ns/100ps
`default_nettype none
// ==========
// pin model
module stm_pin_model (
  output logic ext_clock_pin,
  output logic capture_input_pin,
  output logic internal_high_clock,
  output logic sub_clock
);
  // idle levels; odd periods keep clock phases apart
  initial begin
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    internal_high_clock = 1'b0;
    sub_clock = 1'b0;
  end
  always #110 internal_high_clock = !internal_high_clock;
  always #470 sub_clock = !sub_clock;
  task automatic ext_pulse(input int n);
    repeat (n) begin
      #230 ext_clock_pin = 1'b1;
      #230 ext_clock_pin = 1'b0;
    end
  endtask
  task automatic cap_set(input logic v);
    #310 capture_input_pin = v;
  endtask
endmodule
`default_nettype wire

// *** verification/stm_timer_core_sva.sv ***
// Purpose: port assertions of the timer core
// Assumes: event gaps judged only on the system clock select
// Notes: any write spoils a gap until the next event
`timescale 1ns/100ps
`default_nettype none
`include "stm_consts.vh"
// ==========
// checker
module stm_timer_core_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`STM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ext_clock_pin,
  input wire capture_input_pin,
  input wire internal_high_clock,
  input wire sub_clock,
  input wire timer_output,
  input wire timer_output_b,
  input wire compare_a_event,
  input wire period_event
);
  reg [7:0] c0_q, c1_q, pr_q;
  reg [15:0] ca_q, ga_q, gp_q;
  reg va_q, vp_q;
  wire wr = psel && penable && pwrite && pready;
  wire run = c0_q[7:3] == 5'h03;
  wire ev = compare_a_event || period_event;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow of writes and gap counters between events
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {c0_q, c1_q, pr_q, ca_q} <= 40'h00_0000_0000;
      {ga_q, gp_q, va_q, vp_q} <= 34'h0_0000_0000;
    end else begin
      ga_q <= compare_a_event ? 16'h0000 : ga_q + 16'h0001;
      gp_q <= period_event ? 16'h0000 : gp_q + 16'h0001;
      va_q <= !wr && (va_q || compare_a_event);
      vp_q <= !wr && (vp_q || period_event);
      if (wr && paddr == `STM_OFS_CTRL0) c0_q <= pwdata[7:0];
      if (wr && paddr == `STM_OFS_CTRL1) c1_q <= pwdata[7:0];
      if (wr && paddr == `STM_OFS_CMPA_LO) ca_q[7:0] <= pwdata[7:0];
      if (wr && paddr == `STM_OFS_CMPA_HI) ca_q[15:8] <= pwdata[7:0];
      if (wr && paddr == `STM_OFS_PERIOD) pr_q <= pwdata[7:0];
    end
  end
  property p_gap_a;
    compare_a_event && va_q && run && c1_q[0] && c1_q[7] == c1_q[6]
      && ca_q != 16'h0000 |-> ga_q == ca_q - 16'h0001;
  endproperty
  a_gap_a: assert property (p_gap_a) else $error("compare gap wrong");
  property p_gap_p;
    period_event && vp_q && run && c1_q[1:0] == 2'b00 && pr_q != 8'h00
      && c1_q[7:6] != `STM_MODE_CAP |-> gp_q == {pr_q, 8'h00} - 16'h0001;
  endproperty
  a_gap_p: assert property (p_gap_p) else $error("period gap wrong");
  property p_off;
    !c0_q[3] && !$past(c0_q[3], 2) |-> !ev;
  endproperty
  a_off: assert property (p_off) else $error("event while off");
  property p_pause;
    c0_q[7] && $past(c0_q[7], 2) |-> !ev;
  endproperty
  a_pause: assert property (p_pause) else $error("event in pause");
  property p_rd0;
    psel && penable && !pwrite && paddr == `STM_OFS_CTRL0
      |-> prdata[7:0] == {c0_q[7:3], 3'b000};
  endproperty
  a_rd0: assert property (p_rd0) else $error("control 0 read wrong");
  property p_err;
    psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h18);
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_outb;
    timer_output_b == !timer_output;
  endproperty
  a_outb: assert property (p_outb) else $error("outputs not inverse");
  property p_init;
    $rose(c0_q[3]) && c1_q[7:6] == `STM_MODE_CMP
      |-> ##[0:2] timer_output == (c1_q[3] ^ c1_q[2]);
  endproperty
  a_init: assert property (p_init) else $error("initial level wrong");
endmodule
bind stm_timer_core stm_timer_core_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .ext_clock_pin, .capture_input_pin,
  .internal_high_clock, .sub_clock, .timer_output, .timer_output_b,
  .compare_a_event, .period_event
);
`default_nettype wire

// *** verification/test_standard_timer_module_core.sv ***
// Purpose: self-checking bench of the timer core
// Assumes: APB master in tasks, pins from the partner model
// Notes: register images and event counts give expectations
`timescale 1ns/100ps
`default_nettype none
`include "stm_consts.vh"
// ==========
// bench top
module test_standard_timer_module_core;
  logic pclk, presetn, psel, penable, pwrite, er, o, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] c1, c2;
  logic [7:0] mdl [0:6];
  logic [7:0] pw [0:3] = '{8'h88, 8'h98, 8'hA8, 8'hAA};
  int ph [0:3] = '{0, 256, 64, 256};
  int cp [0:3] = '{1, 1, 2, 0};
  int num_errors, cmp_count, na, np, n0, hi;
  wire [31:0] prdata;
  wire pready, pslverr, ext_clock_pin, capture_input_pin;
  wire internal_high_clock, sub_clock, timer_output, timer_output_b;
  wire compare_a_event, period_event;
  stm_timer_core u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_clock_pin, .capture_input_pin,
    .internal_high_clock, .sub_clock, .timer_output, .timer_output_b,
    .compare_a_event, .period_event
  );
  stm_pin_model u_pins (
    .ext_clock_pin, .capture_input_pin, .internal_high_clock, .sub_clock
  );
  // clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = !pclk;
  end
  // event counts for the scenarios
  always @(posedge pclk) begin
    if (compare_a_event === 1'b1) na <= na + 1;
    if (period_event === 1'b1) np <= np + 1;
  end
  task automatic check(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // apb master: hold the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // write with image update; counter writes are dropped
  task automatic wr(input int i, input logic [7:0] v);
    apb(1'b1, 8'(i * 4), {24'h00_0000, v});
    if (i != 2 && i != 3) mdl[i] = (i == 0) ? (v & 8'hF8) : v;
  endtask
  task automatic rdc(input int i);
    apb(1'b0, 8'(i * 4), 32'h0000_0000);
    check("register", {24'h00_0000, mdl[i]}, rd);
  endtask
  task automatic cnt(output logic [15:0] v);
    apb(1'b0, `STM_OFS_CNT_LO, 32'h0000_0000);
    v[7:0] = rd[7:0];
    apb(1'b0, `STM_OFS_CNT_HI, 32'h0000_0000);
    v[15:8] = rd[7:0];
  endtask
  task automatic wait_ev(input logic per);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((per ? period_event : compare_a_event) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    mdl = '{default: 8'h00};
    rd = $urandom(32'h0a6e);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 7; i++) rdc(i);
    repeat (4) begin
      for (int i = 0; i < 7; i++) wr(i, 8'($urandom) & 8'h77);
      apb(1'b1, 8'h1C, $urandom);
      check("wr_err", 1, er);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      check("rd_err", 1, er);
      check("rd_zero", 0, rd);
      for (int i = 0; i < 7; i++) rdc(i);
    end
    // compare outputs after three matches
    wr(4, 8'h28);
    wr(5, 8'h00);
    for (int f = 0; f < 4; f++) begin
      o = 1'($urandom);
      wr(0, 8'h10);
      wr(1, {2'b00, 2'(f), o, 3'b001});
      wr(0, 8'h18);
      n0 = np;
      repeat (3) wait_ev(1'b0);
      repeat (2) @(posedge pclk);
      e = (f == 0) ? o : (f == 1) ? 1'b0 : (f == 2) ? 1'b1 : !o;
      check("cmp_out", e, timer_output);
      check("no_period", n0, np);
    end
    // pause then disable both hold the count
    for (int k = 0; k < 2; k++) begin
      wr(0, k ? 8'h10 : 8'h98);
      cnt(c1);
      repeat (20) @(posedge pclk);
      cnt(c2);
      check("held", c1, c2);
      check("below_cmpa", 1, c1 < 16'h0028);
      wr(0, 8'h18);
    end
    wr(0, 8'h98);
    cnt(c2);
    check("restart", 1, c2 < 16'h0008);
    // every clock select, overflow only
    wr(0, 8'h00);
    wr(6, 8'h00);
    wr(1, 8'hC0);
    for (int s = 0; s < 8; s++) begin
      wr(0, 8'h00);
      wr(0, {1'b0, 3'(s), 4'h8});
      if (s > 5) u_pins.ext_pulse(10);
      else repeat (400) @(posedge pclk);
      repeat (10) @(posedge pclk);
      wr(0, {1'b1, 3'(s), 4'h8});
      cnt(c1);
      if (s > 5) check("ext_count", 10, c1);
      else check("int_count", 1, c1 != 16'h0000);
    end
    // period match every 256 clocks
    wr(0, 8'h00);
    wr(6, 8'h01);
    wr(0, 8'h18);
    repeat (3) wait_ev(1'b1);
    // pwm functions and duty swap, 256 clocks counted each
    wr(4, 8'h40);
    for (int f = 0; f < 4; f++) begin
      wr(0, 8'h10);
      wr(1, pw[f]);
      wr(0, 8'h18);
      wait_ev(f < 3);
      hi = 0;
      repeat (256) begin
        @(posedge pclk);
        hi += (timer_output === 1'b1);
      end
      check("pwm_high", ph[f], hi);
    end
    // single pulse, run twice so the residual count is known
    wr(0, 8'h10);
    wr(1, 8'hB8);
    repeat (2) begin
      wr(0, 8'h18);
      hi = 0;
      repeat (150) begin
        @(posedge pclk);
        hi += (timer_output === 1'b1);
      end
    end
    check("pulse_high", 64, hi);
    cnt(c1);
    check("pulse_stop", 16'h0040, c1);
    // capture edge selects, compare-A kept out of reach
    for (int f = 0; f < 4; f++) begin
      wr(0, 8'h10);
      wr(5, 8'hFF);
      wr(1, {2'b01, 2'(f), 4'h0});
      wr(0, 8'h18);
      n0 = na;
      u_pins.cap_set(1'b1);
      repeat (10) @(posedge pclk);
      u_pins.cap_set(1'b0);
      repeat (10) @(posedge pclk);
      check("captures", cp[f], na - n0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
